// *** logic/sasr_pkg.sv ***
// Shared constants, types and helpers for the serial audio slot link
package sasr_pkg;
  // Timing figures in their own units, converted to aclk cycles below
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_TIMEOUT_44K_US = 2900;
  localparam int WD_TIMEOUT_STD_US = 2700;
  localparam int LOCK_LOSS_NS = 640;
  localparam int LINK_HOLD_NS = 2000;
  // Longest times round down
  localparam int WD_CYCLES_44K = WD_TIMEOUT_44K_US * 1000 / CLK_PERIOD_NS;
  localparam int WD_CYCLES_STD = WD_TIMEOUT_STD_US * 1000 / CLK_PERIOD_NS;
  localparam int LOCK_LOSS_CYCLES = LOCK_LOSS_NS / CLK_PERIOD_NS;
  // Least time rounds up
  localparam int LINK_HOLD_CYCLES = (LINK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Word layout
  localparam int SAMPLE_BITS = 24;
  localparam logic [9:0] STEREO_BITS = 10'h040;
  localparam logic [9:0] WS_HIGH_STEREO = 10'h020;
  // Format and rate codes
  localparam logic [1:0] FMT_STEREO = 2'h0;
  localparam logic [1:0] FMT_TDM4 = 2'h1;
  localparam logic [1:0] FMT_TDM8 = 2'h2;
  localparam logic [1:0] FMT_TDM16 = 2'h3;
  localparam logic [2:0] RATE_44K1 = 3'h0;
  localparam logic [2:0] RATE_48K = 3'h1;
  localparam logic [2:0] RATE_96K = 3'h2;
  localparam logic [2:0] RATE_192K = 3'h3;
  // Source register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_WSH = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_SLOT_BASE = 8'h40;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FMT_LSB = 1;
  localparam int STATUS_FRAMES_LSB = 16;
  localparam logic [7:0] DIV_RESET = 8'h03;
  localparam logic [8:0] WSH_RESET = 9'h020;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_IDLE = 2'b01,
    SRC_RUN = 2'b10
  } sasr_src_state_t;

  // Bit clocks per frame: 64, 128, 256 or 512
  function automatic logic [9:0] frame_bits(input logic [1:0] fmt);
    frame_bits = STEREO_BITS << fmt;
  endfunction : frame_bits

  // Highest rate allowed for each format
  function automatic logic rate_ok(input logic [1:0] fmt, input logic [2:0] rate);
    rate_ok = (rate <= RATE_192K) && !(fmt == FMT_TDM8 && rate > RATE_96K)
      && !(fmt == FMT_TDM16 && rate > RATE_48K);
  endfunction : rate_ok
endpackage : sasr_pkg

// *** logic/sasr_link_if.sv ***
// Serial audio link between the source and the receiver
`timescale 1ns/100ps
interface sasr_link_if;
  logic serial_bit_clock_pin;
  logic frame_sync_pin;
  logic serial_data_pin;
  modport device (
    input serial_bit_clock_pin,
    input frame_sync_pin,
    input serial_data_pin
  );
  modport source (
    output serial_bit_clock_pin,
    output frame_sync_pin,
    output serial_data_pin
  );
endinterface : sasr_link_if

// *** logic/sasr_receiver.sv ***
// Receiver end of the serial audio slot link
`timescale 1ns/100ps
// Function
// - Source toggles frame sync at sample rate
// - Format select: stereo, 4, 8, 16 slots
// - 32-bit words MSB first, top 24 kept
// - Lost bit clock drops lock, forces standby
// - Host programs format and rate to match
// - Stereo mode bit clock is 64 fs
// - Stereo: slot 0 right, slot 1 left
// - Four slots: bit clock is 128 fs
// - Eight slots: bit clock is 256 fs
// - Sixteen slots: bit clock is 512 fs
// - Slot select is binary slot index
// - Frame sync high 32, or 1 to slots*32-1
// - Data and sync taken on rising edge
// - Frame length checked every frame, flag set
// - Watchdog timeout mutes and flags, sync releases
module sasr_receiver
  import sasr_pkg::*;
#(
  parameter int WD_44K_CYCLES = WD_CYCLES_44K,
  parameter int WD_STD_CYCLES = WD_CYCLES_STD
) (
  input wire logic aclk,
  input wire logic aresetn,
  sasr_link_if.device link,
  input wire logic [1:0] format_select,
  input wire logic [2:0] sample_rate_select,
  input wire logic [3:0] slot_select,
  input wire logic clock_watchdog_enable,
  input wire logic frame_error_clear,
  input wire logic clock_timeout_clear,
  output logic [23:0] sample_data,
  output logic sample_valid,
  output logic frame_error_flag,
  output logic clock_timeout_flag,
  output logic mute_request,
  output logic pll_locked,
  output logic standby_request,
  output logic config_error
);
  localparam int EV_ACT = 0;
  localparam int EV_FS = 1;
  localparam int EV_ERR = 2;
  localparam int EV_SMP = 3;
  localparam logic [7:0] HOLD_LAST = 8'(LINK_HOLD_CYCLES - 1);
  localparam logic [6:0] LOCK_LAST = 7'(LOCK_LOSS_CYCLES - 1);
  localparam logic [9:0] CNT_MAX = 10'h3FF;

  logic bclk;
  logic link_hold;
  logic [7:0] hold_cnt;
  logic [6:0] cfg_s1;
  logic [6:0] cfg_s2;
  logic [6:0] cfg_s3;
  logic [6:0] cfg_l;
  logic link_rst;
  logic [1:0] l_fmt;
  logic [3:0] l_slot;
  logic ws_prev;
  logic ws_rise;
  logic synced;
  logic [9:0] bit_cnt;
  logic frame_ok;
  logic act_tgl;
  logic fs_tgl;
  logic err_tgl;
  logic smp_tgl;
  logic got;
  logic [23:0] shift;
  logic [23:0] held;
  logic [3:0] tg_s1;
  logic [3:0] tg_s2;
  logic [3:0] tg_s3;
  logic [3:0] tg_acc;
  logic [3:0] tg_evt;
  logic [6:0] lock_cnt;
  logic [18:0] wd_cnt;
  logic [18:0] wd_limit;
  logic wd_hit;

  assign bclk = link.serial_bit_clock_pin;

  // Hold the link side in reset until the bit clock has had time to flush it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt <= 8'h00;
      link_hold <= 1'b1;
    end else if (hold_cnt == HOLD_LAST) begin
      link_hold <= 1'b0;
    end else begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  // Hold and static config cross as a group; taken only once two stages agree
  always_ff @(posedge bclk) begin
    cfg_s1 <= {link_hold, format_select, slot_select};
    cfg_s2 <= cfg_s1;
    cfg_s3 <= cfg_s2;
    if (cfg_s2 == cfg_s3) begin
      cfg_l <= cfg_s3;
    end
  end

  assign link_rst = cfg_l[6];
  assign l_fmt = cfg_l[5:4];
  assign l_slot = cfg_l[3:0];
  assign ws_rise = link.frame_sync_pin & ~ws_prev;
  assign frame_ok = synced && (bit_cnt == frame_bits(l_fmt) - 10'h001);

  // Frame position counter and length check, all on the bit clock rising edge
  always_ff @(posedge bclk) begin
    if (link_rst) begin
      ws_prev <= 1'b0;
      synced <= 1'b0;
      bit_cnt <= 10'h000;
      act_tgl <= 1'b0;
      fs_tgl <= 1'b0;
      err_tgl <= 1'b0;
    end else begin
      act_tgl <= ~act_tgl;
      ws_prev <= link.frame_sync_pin;
      if (ws_rise) begin
        bit_cnt <= 10'h000;
        synced <= 1'b1;
        fs_tgl <= ~fs_tgl;
        if (synced && !frame_ok) begin
          err_tgl <= ~err_tgl;
        end
      end else if (bit_cnt != CNT_MAX) begin
        bit_cnt <= bit_cnt + 10'h001;
      end
    end
  end

  // Data lags frame sync by one bit, so bit_cnt is the bit index of the frame
  always_ff @(posedge bclk) begin
    if (link_rst) begin
      shift <= 24'h00_0000;
      held <= 24'h00_0000;
      got <= 1'b0;
      smp_tgl <= 1'b0;
    end else if (ws_rise) begin
      got <= 1'b0;
      // A frame of the wrong length delivers nothing
      if (got && frame_ok) begin
        held <= shift;
        smp_tgl <= ~smp_tgl;
      end
    end else if (bit_cnt[9:5] == {1'b0, l_slot}
        && bit_cnt[4:0] < 5'(SAMPLE_BITS)) begin
      shift <= {shift[22:0], link.serial_data_pin};
      if (bit_cnt[4:0] == 5'(SAMPLE_BITS - 1)) begin
        got <= 1'b1;
      end
    end
  end

  // Link toggles into aclk; an edge counts when stages two and three agree
  always_ff @(posedge aclk) begin
    tg_s1 <= {smp_tgl, err_tgl, fs_tgl, act_tgl};
    tg_s2 <= tg_s1;
    tg_s3 <= tg_s2;
  end

  // Events are ignored while the link side is still being flushed
  assign tg_evt = (tg_s2 ~^ tg_s3) & (tg_s3 ^ tg_acc) & {4{~link_hold}};

  always_ff @(posedge aclk) begin
    if (!aresetn || link_hold) begin
      tg_acc <= 4'h0;
    end else begin
      tg_acc <= tg_acc ^ tg_evt;
    end
  end

  // Lock follows bit clock activity; silence beyond the window means standby
  always_ff @(posedge aclk) begin
    if (!aresetn || link_hold) begin
      lock_cnt <= 7'h00;
      pll_locked <= 1'b0;
      standby_request <= 1'b1;
    end else if (tg_evt[EV_ACT]) begin
      lock_cnt <= 7'h00;
      pll_locked <= 1'b1;
      standby_request <= 1'b0;
    end else if (lock_cnt == LOCK_LAST) begin
      pll_locked <= 1'b0;
      standby_request <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 7'h01;
    end
  end

  // Watchdog limit depends on the programmed sample rate
  assign wd_limit = (sample_rate_select == RATE_44K1) ? 19'(WD_44K_CYCLES - 1)
    : 19'(WD_STD_CYCLES - 1);
  assign wd_hit = clock_watchdog_enable && !tg_evt[EV_FS] && (wd_cnt >= wd_limit);

  // Frame sync restarts the timer and lifts the mute; a timeout mutes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt <= 19'h0_0000;
      mute_request <= 1'b0;
    end else if (tg_evt[EV_FS] || !clock_watchdog_enable) begin
      wd_cnt <= 19'h0_0000;
      mute_request <= 1'b0;
    end else if (wd_hit) begin
      mute_request <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 19'h0_0001;
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_error_flag <= 1'b0;
      clock_timeout_flag <= 1'b0;
    end else begin
      frame_error_flag <= (frame_error_flag & ~frame_error_clear) | tg_evt[EV_ERR];
      clock_timeout_flag <= (clock_timeout_flag & ~clock_timeout_clear) | wd_hit;
    end
  end

  // Held word stays put for a whole frame, far longer than the toggle takes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_data <= 24'h00_0000;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= tg_evt[EV_SMP];
      if (tg_evt[EV_SMP]) begin
        sample_data <= held;
      end
    end
  end

  // Unsupported format and rate pairs are reported, not corrected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_error <= 1'b0;
    end else begin
      config_error <= !rate_ok(format_select, sample_rate_select);
    end
  end
endmodule : sasr_receiver

// *** logic/sasr_source.sv ***
// Audio source end: AXI4-Lite controlled serial frame generator
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module sasr_source
  import sasr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  sasr_link_if.source link
);
  logic aw_got;
  logic w_got;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_go;
  logic run;
  logic [1:0] fmt;
  logic [1:0] fmt_run;
  logic [7:0] div;
  logic [8:0] wsh;
  logic [31:0] slot_word [16];
  logic [15:0] frames;
  logic [31:0] rd_word;
  logic [7:0] div_cnt;
  logic bclk_q;
  logic fall;
  logic fs_q;
  logic sd_q;
  logic [9:0] pos;
  logic [9:0] last;
  logic [9:0] ws_len;
  sasr_src_state_t state;

  // Mapped and word aligned addresses only
  function automatic logic known(input logic [7:0] a);
    known = (a[1:0] == 2'h0) && (a <= REG_STATUS || a[7:6] == REG_SLOT_BASE[7:6]);
  endfunction : known

  assign wr_go = aw_got && w_got && !bvalid;
  assign link.serial_bit_clock_pin = bclk_q;
  assign link.frame_sync_pin = fs_q;
  assign link.serial_data_pin = sd_q;

  // Write channels taken in either order; response once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_q <= 8'(awaddr);
        awready <= 1'b0;
      end else if (!aw_got && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
        wready <= 1'b0;
      end else if (!w_got && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= known(aw_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'b0;
      fmt <= FMT_STEREO;
      div <= DIV_RESET;
      wsh <= WSH_RESET;
    end else if (wr_go && ws_q[0]) begin
      case (aw_q)
        REG_CTRL: begin
          run <= wd_q[CTRL_RUN_BIT];
          fmt <= wd_q[CTRL_FMT_LSB +: 2];
        end
        REG_DIV: div <= wd_q[7:0];
        REG_WSH: wsh <= {ws_q[1] ? wd_q[8] : wsh[8], wd_q[7:0]};
        default: ;
      endcase
    end else if (wr_go && ws_q[1] && aw_q == REG_WSH) begin
      wsh[8] <= wd_q[8];
    end
  end

  // Slot words, byte lanes honoured; a write during a frame may tear one word
  always_ff @(posedge aclk) begin
    if (wr_go && aw_q[7:6] == REG_SLOT_BASE[7:6] && aw_q[1:0] == 2'h0) begin
      for (int b = 0; b < 4; b++) begin
        if (ws_q[b]) begin
          slot_word[aw_q[5:2]][8*b +: 8] <= wd_q[8*b +: 8];
        end
      end
    end
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (araddr[7:6] == REG_SLOT_BASE[7:6]) begin
      rd_word = slot_word[araddr[5:2]];
    end else begin
      case (8'(araddr))
        REG_CTRL: rd_word = {29'h0, fmt, run};
        REG_DIV: rd_word = {24'h00_0000, div};
        REG_WSH: rd_word = {23'h00_0000, wsh};
        REG_STATUS: rd_word = {frames, 15'h0000, state == SRC_RUN};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= known(8'(araddr)) ? rd_word : 32'h0000_0000;
      rresp <= known(8'(araddr)) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Bit clock divider runs free from reset release; half period is div cycles, or one cycle when div is 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 8'h00;
      bclk_q <= 1'b0;
    end else if (div_cnt == 8'h00) begin
      bclk_q <= ~bclk_q;
      div_cnt <= (div == 8'h00) ? 8'h00 : div - 8'h01;
    end else begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  assign fall = bclk_q && div_cnt == 8'h00;
  assign last = frame_bits(fmt_run) - 10'h001;
  // Stereo sync is fixed; slot modes clamp the register into 1 .. frame-1
  assign ws_len = (fmt_run == FMT_STEREO) ? WS_HIGH_STEREO
    : (wsh == 9'h000) ? 10'h001 : ({1'b0, wsh} > last) ? last : {1'b0, wsh};

  // Frame generator; outputs change on the falling edge so the receiver
  // sees them stable at the rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SRC_IDLE;
      fmt_run <= FMT_STEREO;
      pos <= 10'h000;
      fs_q <= 1'b0;
      sd_q <= 1'b0;
      frames <= 16'h0000;
    end else if (fall) begin
      case (state)
        SRC_IDLE: begin
          if (run) begin
            state <= SRC_RUN;
            fmt_run <= fmt;
            pos <= 10'h000;
            fs_q <= 1'b1;
          end
        end
        SRC_RUN: begin
          // Bit q of the frame goes out at position q+1, MSB first
          sd_q <= slot_word[pos[8:5]][~pos[4:0]];
          if (pos == last) begin
            frames <= frames + 16'h0001;
            pos <= 10'h000;
            fs_q <= run;
            if (!run) begin
              state <= SRC_IDLE;
              sd_q <= 1'b0;
            end
          end else begin
            pos <= pos + 10'h001;
            fs_q <= (pos + 10'h001) < ws_len;
          end
        end
        default: state <= SRC_IDLE;
      endcase
    end
  end
endmodule : sasr_source

// *** dv/sasr_link_asserts.sv ***
// Concurrent checks on the serial audio link and the receiver outputs
`timescale 1ns/100ps
module sasr_link_asserts
  import sasr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_bit_clock_pin,
  input wire logic frame_sync_pin,
  input wire logic [1:0] format_select,
  input wire logic [2:0] sample_rate_select,
  input wire logic clock_watchdog_enable,
  input wire logic frame_error_clear,
  input wire logic [23:0] sample_data,
  input wire logic sample_valid,
  input wire logic frame_error_flag,
  input wire logic clock_timeout_flag,
  input wire logic mute_request,
  input wire logic pll_locked,
  input wire logic standby_request,
  input wire logic config_error
);
  logic [9:0] hi_cnt;
  logic [7:0] idle_cnt;
  logic bck_q;
  // Sync high length in bit clocks, cleared whenever sync is low
  always_ff @(posedge serial_bit_clock_pin) begin
    if (!frame_sync_pin) hi_cnt <= 10'h000;
    else hi_cnt <= hi_cnt + 10'h001;
  end
  // Aclk cycles since the bit clock last moved; saturates so it never wraps back
  always_ff @(posedge aclk) begin
    bck_q <= serial_bit_clock_pin;
    if (!aresetn || bck_q != serial_bit_clock_pin) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
  end
  AST_VALID_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_valid |=> !sample_valid) else $error("valid longer than one cycle");
  AST_DATA_WITH_VALID: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(sample_data) |-> sample_valid) else $error("sample changed without valid");
  AST_STANDBY: assert property (@(posedge aclk) disable iff (!aresetn)
    standby_request != pll_locked) else $error("standby not the inverse of lock");
  AST_LOCK_LOSS: assert property (@(posedge aclk) disable iff (!aresetn)
    idle_cnt == 8'h50 |-> !pll_locked) else $error("still locked without bit clock");
  AST_FERR_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_error_flag && !frame_error_clear |=> frame_error_flag) else $error("frame flag lost");
  AST_MUTE_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    !clock_watchdog_enable [*2] |-> !mute_request) else $error("mute with watchdog off");
  AST_TIMEOUT_MUTE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(clock_timeout_flag) |-> ##[0:2] mute_request) else $error("timeout without mute");
  AST_CFG_16: assert property (@(posedge aclk) disable iff (!aresetn)
    (format_select == FMT_TDM16 && sample_rate_select > RATE_48K) [*2] |-> config_error)
    else $error("sixteen slots above 48k accepted");
  AST_CFG_OK: assert property (@(posedge aclk) disable iff (!aresetn)
    (format_select == FMT_STEREO && sample_rate_select <= RATE_192K) [*2] |-> !config_error)
    else $error("stereo pair refused");
  AST_STEREO_SYNC: assert property (@(posedge serial_bit_clock_pin) disable iff (!aresetn)
    $fell(frame_sync_pin) && format_select == FMT_STEREO |-> hi_cnt == 10'h020)
    else $error("stereo sync high time wrong");
  // Main scenarios reached
  COV_SAMPLE: cover property (@(posedge aclk) disable iff (!aresetn) sample_valid);
  COV_FERR: cover property (@(posedge aclk) disable iff (!aresetn) $rose(frame_error_flag));
  COV_TIMEOUT: cover property (@(posedge aclk) disable iff (!aresetn) $rose(clock_timeout_flag));
  COV_UNLOCK: cover property (@(posedge aclk) disable iff (!aresetn) $fell(pll_locked));
endmodule : sasr_link_asserts

// *** dv/test_serial_audio_slot_receiver.sv ***
// Self-checking bench: AXI-driven source feeding the slot receiver over the link
`timescale 1ns/100ps
module test_serial_audio_slot_receiver
  import sasr_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, clock_watchdog_enable, frame_error_clear, clock_timeout_clear;
  logic sample_valid, frame_error_flag, clock_timeout_flag, mute_request;
  logic pll_locked, standby_request, config_error;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd;
  logic [3:0] wstrb, slot_select;
  logic [1:0] bresp, rresp, rsp, format_select;
  logic [2:0] sample_rate_select;
  logic [23:0] sample_data;
  logic [31:0] words [16];
  int miscompares, num_checks, n;
  sasr_link_if link_if();
  sasr_source u_sasr_source (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .link(link_if));
  // Short watchdog counts keep the timeout scenario to a few thousand cycles
  sasr_receiver #(.WD_44K_CYCLES(2000), .WD_STD_CYCLES(1800)) u_sasr_receiver (.aclk,
    .aresetn, .link(link_if), .format_select, .sample_rate_select, .slot_select,
    .clock_watchdog_enable, .frame_error_clear, .clock_timeout_clear, .sample_data,
    .sample_valid, .frame_error_flag, .clock_timeout_flag, .mute_request, .pll_locked,
    .standby_request, .config_error);
  sasr_link_asserts u_sasr_link_asserts (.aclk, .aresetn,
    .serial_bit_clock_pin(link_if.serial_bit_clock_pin), .frame_sync_pin(link_if.frame_sync_pin),
    .format_select, .sample_rate_select, .clock_watchdog_enable, .frame_error_clear,
    .sample_data, .sample_valid, .frame_error_flag, .clock_timeout_flag, .mute_request,
    .pll_locked, .standby_request, .config_error);
  // 100 MHz system clock; the bit clock comes from the source divider
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results();
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // Write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    check("bresp", 32'(bresp), 32'(er));
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : axi_read
  task automatic wait_valid();
    int k;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (sample_valid !== 1'h1 && k < 10000);
    check("sample_valid", 32'(sample_valid), 32'h0000_0001);
  endtask : wait_valid
  task automatic pulse_clear(input logic timeout);
    if (timeout) clock_timeout_clear <= 1'h1;
    else frame_error_clear <= 1'h1;
    @(posedge aclk);
    clock_timeout_clear <= 1'h0;
    frame_error_clear <= 1'h0;
  endtask : pulse_clear
  // Stop, reprogram both ends for one format, restart and compare the picked slot
  task automatic run_format(input int f);
    int ns;
    logic [3:0] sel;
    ns = 2 << f;
    axi_write(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (4200) @(posedge aclk);
    for (int k = 0; k < ns; k++) begin
      words[k] = $random(seed);
      axi_write(8'(REG_SLOT_BASE + 4 * k), words[k], RESP_OKAY);
    end
    // Highest slot and a one-bit sync are the corner for sixteen slots
    sel = (f == 3) ? 4'hF : 4'($unsigned($random(seed)) % ns);
    if (f > 0) axi_write(REG_WSH, (f == 3) ? 32'h0000_0001 : 32'($unsigned($random(seed)) % (ns * 32 - 1) + 1), RESP_OKAY);
    format_select <= 2'(f);
    slot_select <= sel;
    sample_rate_select <= (f == 3) ? RATE_48K : (f == 2) ? RATE_96K : RATE_192K;
    axi_write(REG_CTRL, 32'((f << CTRL_FMT_LSB) | 1), RESP_OKAY);
    wait_valid();
    pulse_clear(1'h0);
    repeat (2) begin
      wait_valid();
      check("sample_data", 32'(sample_data), 32'(words[sel][31:8]));
    end
    check("frame_error_flag", 32'(frame_error_flag), 32'h0000_0000);
  endtask : run_format
  // Hang guard, well past the roughly 50k cycles the sequence needs
  initial begin
    #950000;
    miscompares++;
    results();
  end
  initial begin
    seed = 32'h0000_e01c;
    {awvalid, wvalid, bready, arvalid, rready, clock_watchdog_enable} = 6'h00;
    {frame_error_clear, clock_timeout_clear} = 2'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {format_select, sample_rate_select, slot_select} = '0;
    aresetn = 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(REG_DIV, rd, rsp);
    check("div", rd, 32'(DIV_RESET));
    axi_read(REG_WSH, rd, rsp);
    check("wsh", rd, 32'(WSH_RESET));
    axi_read(8'h30, rd, rsp);
    check("unmapped", 32'(rsp), 32'(RESP_SLVERR));
    axi_write(8'h31, 32'h0000_0001, RESP_SLVERR);
    for (int f = 0; f < 4; f++) begin
      for (int r = 0; r < 8; r++) begin
        format_select <= 2'(f);
        sample_rate_select <= 3'(r);
        repeat (3) @(posedge aclk);
        check("config_error", 32'(config_error), 32'(r > 3 || (f == 3 && r > 1) || (f == 2 && r > 2)));
      end
    end
    repeat (300) @(posedge aclk);
    check("pll_locked", 32'(pll_locked), 32'h0000_0001);
    for (int f = 0; f < 4; f++) run_format(f);
    axi_read(REG_STATUS, rd, rsp);
    check("running", 32'(rd[0]), 32'h0000_0001);
    // Stereo stream against a four-slot receiver: every frame is the wrong length
    axi_write(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (4200) @(posedge aclk);
    format_select <= FMT_TDM4;
    axi_write(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    repeat (700) @(posedge aclk);
    pulse_clear(1'h0);
    n = 0;
    repeat (1500) begin
      @(posedge aclk);
      if (sample_valid === 1'h1) n++;
    end
    check("frame_error_flag", 32'(frame_error_flag), 32'h0000_0001);
    check("dropped_valid", 32'(n), 32'h0000_0000);
    // Watchdog at 44.1k: quiet while frames flow, fires once they stop
    format_select <= FMT_STEREO;
    sample_rate_select <= RATE_44K1;
    clock_watchdog_enable <= 1'h1;
    repeat (3000) @(posedge aclk);
    check("mute_request", 32'(mute_request), 32'h0000_0000);
    axi_write(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (1400) @(posedge aclk);
    check("mute_request", 32'(mute_request), 32'h0000_0000);
    repeat (800) @(posedge aclk);
    check("mute_request", 32'(mute_request), 32'h0000_0001);
    check("clock_timeout_flag", 32'(clock_timeout_flag), 32'h0000_0001);
    axi_write(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    repeat (200) @(posedge aclk);
    check("mute_request", 32'(mute_request), 32'h0000_0000);
    check("clock_timeout_flag", 32'(clock_timeout_flag), 32'h0000_0001);
    pulse_clear(1'h1);
    repeat (2) @(posedge aclk);
    check("clock_timeout_flag", 32'(clock_timeout_flag), 32'h0000_0000);
    clock_watchdog_enable <= 1'h0;
    // A very slow bit clock looks missing and must drop lock
    axi_write(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    axi_write(REG_DIV, 32'h0000_00FF, RESP_OKAY);
    n = 0;
    while (pll_locked !== 1'h0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    check("pll_locked", 32'(pll_locked), 32'h0000_0000);
    check("standby_request", 32'(standby_request), 32'h0000_0001);
    axi_write(REG_DIV, 32'(DIV_RESET), RESP_OKAY);
    repeat (600) @(posedge aclk);
    check("pll_locked", 32'(pll_locked), 32'h0000_0001);
    results();
  end
endmodule : test_serial_audio_slot_receiver
